// ### core/power_event_detect_and_pin_map.sv
// Event detection, latching and routing to two alert pins
// Function
// - Each data-ready compares mean-square voltage with sag and surge limits.
// - Overcurrent and overpower evaluate once per computation cycle.
// - Sag and surge latch through bits 6 and 7 like the other events; they update per sample.
// - Routed sag or surge drives its pin high.
// - RMS current above limit sets overcurrent flag and drives routed pins.
// - Active power above limit sets overpower flag and drives routed pins.
// - Voltage falling through save level starts an energy save.
// - Voltage first above restore level after reset reloads energy; later rises only re-arm the save; gap gives hysteresis.
// - Save and restore set no event flag or status bit.
// - Bits 28,23,22,21,20 route hot,watts,amps,swell,dip to pin b.
// - Bits 27,19,18,17,16 route hot,watts,amps,swell,dip to pin a.
// - Bit 15 drives pin b manually, bit 14 drives pin a.
// - Writing 1 to bits 26,11,10,9,8 clears the matching event.
// - Latch bits 25,7,6,5,4 hold events until cleared, else follow.
// - Test bits 24,3,2,1 inject simulated hot,swell,dip,watts events.
// - Bits 31-29 and 13-12 read as zero.
// - Reset leaves all events unrouted, unlatched, unsimulated, manual zero.
// - Manual pin control only works while nothing is routed there.
// - A clear bit clears the event then returns to zero itself.
// - Overtemperature compares a 10-bit thermistor result with its limit.
// - Bit 0 injects a simulated overcurrent event while set.
`include "evt_params.svh"

module power_event_detect_and_pin_map #(
   parameter int VW = 32,
   parameter int IW = 32,
   parameter int PW = 32
) (
   input  wire logic                    clk_i,
   input  wire logic                    rst_i,
   // Wishbone classic slave
   input  wire logic                    cyc_i,
   input  wire logic                    stb_i,
   input  wire logic                    we_i,
   input  wire logic [`EVT_ADR_W-1:0]   adr_i,
   input  wire logic [3:0]              sel_i,
   input  wire logic [31:0]             dat_i,
   output logic      [31:0]             dat_o,
   output logic                         ack_o,
   // Measurement engine
   input  wire logic                    data_ready_i,
   input  wire logic                    compute_done_i,
   input  wire logic [VW-1:0]           trailing_mean_square_volts_i,
   input  wire logic [VW-1:0]           rms_volts_i,
   input  wire logic [IW-1:0]           rms_amps_i,
   input  wire logic [PW-1:0]           active_watts_i,
   input  wire logic [`EVT_TEMP_W-1:0]  thermistor_i,
   input  wire logic [IW-1:0]           amps_limit_i,
   input  wire logic [PW-1:0]           watts_limit_i,
   input  wire logic [`EVT_TEMP_W-1:0]  hot_limit_i,
   input  wire logic [VW-1:0]           save_trigger_level_i,
   input  wire logic [VW-1:0]           restore_trigger_level_i,
   // Outputs
   output logic                         alert_pin_a_o,
   output logic                         alert_pin_b_o,
   output logic                         nv_save_o,
   output logic                         nv_restore_o
);
   logic [31:0]            cfg_ff;
   logic [VW-1:0]          dip_limit_ff;
   logic [VW-1:0]          swell_limit_ff;
   logic                   wr_stb;
   logic                   bus_req;
   logic [31:0]            byte_mask;
   logic [31:0]            nxt_cfg;
   logic [`EVT_NUM-1:0]    cond;
   logic [`EVT_NUM-1:0]    eval;
   logic [`EVT_NUM-1:0]    sim;
   logic [`EVT_NUM-1:0]    latch;
   logic [`EVT_NUM-1:0]    clear;
   logic [`EVT_NUM-1:0]    route_a;
   logic [`EVT_NUM-1:0]    route_b;
   logic [`EVT_NUM-1:0]    active;
   logic                   nxt_pin_a;
   logic                   nxt_pin_b;

   // Expands byte selects into a bit mask
   function automatic logic [31:0] lane_mask(input logic [3:0] sel);
      lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
   endfunction : lane_mask

   // Picks one field per event in amps, watts, swell, dip, hot order
   function automatic logic [`EVT_NUM-1:0] pick(input logic [31:0] c, input logic [3:0] lo,
                                                 input int hot_bit);
      pick = {c[hot_bit], c[lo+2'd3], c[lo+2'd2], c[lo+2'd1], c[lo]};
   endfunction : pick

   assign bus_req   = cyc_i && stb_i;
   assign wr_stb    = bus_req && we_i && !ack_o;
   assign byte_mask = lane_mask(sel_i);

   // One wait-free answer per request; ack drops the cycle after it is given
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= bus_req && !ack_o;
      end
   end

   // Clear bits never store, so they read back zero and act once
   always_comb begin
      nxt_cfg = cfg_ff;
      if (wr_stb && adr_i == `EVT_ADR_CFG) begin
         nxt_cfg = (cfg_ff & ~byte_mask) | (dat_i & byte_mask);
      end
      nxt_cfg = nxt_cfg & `EVT_CFG_WMASK;
      nxt_cfg[`EVT_BIT_HOT_CLR] = 1'b0;
      nxt_cfg[`EVT_LSB_CLR +: 4] = 4'h0;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_ff <= `EVT_CFG_RESET;
      end else begin
         cfg_ff <= nxt_cfg;
      end
   end

   // Clear pulses come straight from the write so they act in the write cycle
   always_comb begin
      clear = '0;
      if (wr_stb && adr_i == `EVT_ADR_CFG) begin
         clear = pick(dat_i & byte_mask, `EVT_LSB_CLR, `EVT_BIT_HOT_CLR);
         clear[evt_pkg::EV_AMPS]  = dat_i[`EVT_LSB_CLR + 3] & sel_i[1];
         clear[evt_pkg::EV_WATTS] = dat_i[`EVT_LSB_CLR + 2] & sel_i[1];
         clear[evt_pkg::EV_SWELL] = dat_i[`EVT_LSB_CLR + 1] & sel_i[1];
         clear[evt_pkg::EV_DIP]   = dat_i[`EVT_LSB_CLR] & sel_i[1];
      end
   end

   // Sag and surge limits live in registers here
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dip_limit_ff   <= VW'(`EVT_LIM_RESET);
         swell_limit_ff <= VW'(`EVT_LIM_RESET);
      end else if (wr_stb && adr_i == `EVT_ADR_SAG_LIM) begin
         dip_limit_ff   <= VW'((32'(dip_limit_ff) & ~byte_mask) | (dat_i & byte_mask));
      end else if (wr_stb && adr_i == `EVT_ADR_SURGE_LIM) begin
         swell_limit_ff <= VW'((32'(swell_limit_ff) & ~byte_mask) | (dat_i & byte_mask));
      end
   end

   // Read data registered; unmapped addresses read zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0000_0000;
      end else if (bus_req && !ack_o) begin
         case (adr_i)
            `EVT_ADR_CFG:       dat_o <= cfg_ff;
            `EVT_ADR_STATUS:    dat_o <= {27'h0000000, active};
            `EVT_ADR_SAG_LIM:   dat_o <= 32'(dip_limit_ff);
            `EVT_ADR_SURGE_LIM: dat_o <= 32'(swell_limit_ff);
            default:            dat_o <= 32'h0000_0000;
         endcase
      end
   end

   // Latch bit order in the word is swell, dip, watts, amps
   always_comb begin
      sim   = pick(cfg_ff, `EVT_LSB_SIM, `EVT_BIT_HOT_SIM);
      sim[evt_pkg::EV_AMPS]  = cfg_ff[`EVT_LSB_SIM];
      sim[evt_pkg::EV_WATTS] = cfg_ff[`EVT_LSB_SIM + 1];
      sim[evt_pkg::EV_DIP]   = cfg_ff[`EVT_LSB_SIM + 2];
      sim[evt_pkg::EV_SWELL] = cfg_ff[`EVT_LSB_SIM + 3];
      latch = '0;
      latch[evt_pkg::EV_AMPS]  = cfg_ff[`EVT_LSB_LAT];
      latch[evt_pkg::EV_WATTS] = cfg_ff[`EVT_LSB_LAT + 1];
      latch[evt_pkg::EV_DIP]   = cfg_ff[`EVT_LSB_LAT + 2];
      latch[evt_pkg::EV_SWELL] = cfg_ff[`EVT_LSB_LAT + 3];
      latch[evt_pkg::EV_HOT]   = cfg_ff[`EVT_BIT_HOT_LAT];
      route_a = '0;
      route_b = '0;
      route_a[evt_pkg::EV_DIP]   = cfg_ff[`EVT_LSB_P1];
      route_a[evt_pkg::EV_SWELL] = cfg_ff[`EVT_LSB_P1 + 1];
      route_a[evt_pkg::EV_AMPS]  = cfg_ff[`EVT_LSB_P1 + 2];
      route_a[evt_pkg::EV_WATTS] = cfg_ff[`EVT_LSB_P1 + 3];
      route_a[evt_pkg::EV_HOT]   = cfg_ff[`EVT_BIT_HOT_P1];
      route_b[evt_pkg::EV_DIP]   = cfg_ff[`EVT_LSB_P2];
      route_b[evt_pkg::EV_SWELL] = cfg_ff[`EVT_LSB_P2 + 1];
      route_b[evt_pkg::EV_AMPS]  = cfg_ff[`EVT_LSB_P2 + 2];
      route_b[evt_pkg::EV_WATTS] = cfg_ff[`EVT_LSB_P2 + 3];
      route_b[evt_pkg::EV_HOT]   = cfg_ff[`EVT_BIT_HOT_P2];
   end

   // Conditions and when each one is sampled
   always_comb begin
      cond = '0;
      eval = '0;
      cond[evt_pkg::EV_DIP]   = trailing_mean_square_volts_i < dip_limit_ff;
      cond[evt_pkg::EV_SWELL] = trailing_mean_square_volts_i > swell_limit_ff;
      cond[evt_pkg::EV_AMPS]  = rms_amps_i > amps_limit_i;
      cond[evt_pkg::EV_WATTS] = active_watts_i > watts_limit_i;
      cond[evt_pkg::EV_HOT]   = thermistor_i > hot_limit_i;
      eval[evt_pkg::EV_DIP]   = data_ready_i;
      eval[evt_pkg::EV_SWELL] = data_ready_i;
      eval[evt_pkg::EV_AMPS]  = compute_done_i;
      eval[evt_pkg::EV_WATTS] = compute_done_i;
      eval[evt_pkg::EV_HOT]   = compute_done_i;
   end

   for (genvar g = 0; g < `EVT_NUM; g++) begin : g_flag
      event_flag u_flag (
         .clk_i    (clk_i),
         .rst_i    (rst_i),
         .eval_i   (eval[g]),
         .cond_i   (cond[g]),
         .sim_i    (sim[g]),
         .latch_i  (latch[g]),
         .clear_i  (clear[g]),
         .active_o (active[g])
      );
   end

   // Routed events own the pin; manual bit only when nothing routed
   always_comb begin
      nxt_pin_a = |route_a ? |(active & route_a) : cfg_ff[`EVT_BIT_MAN_A];
      nxt_pin_b = |route_b ? |(active & route_b) : cfg_ff[`EVT_BIT_MAN_B];
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         alert_pin_a_o <= 1'b0;
         alert_pin_b_o <= 1'b0;
      end else begin
         alert_pin_a_o <= nxt_pin_a;
         alert_pin_b_o <= nxt_pin_b;
      end
   end

   // Save/restore pulses touch no flag or status bit
   nv_trigger #(
      .W (VW)
   ) u_nv (
      .clk_i                   (clk_i),
      .rst_i                   (rst_i),
      .eval_i                  (data_ready_i),
      .volts_i                 (rms_volts_i),
      .save_trigger_level_i    (save_trigger_level_i),
      .restore_trigger_level_i (restore_trigger_level_i),
      .save_o                  (nv_save_o),
      .restore_o               (nv_restore_o)
   );
endmodule : power_event_detect_and_pin_map

// ### core/evt_params.svh
// Register offsets, bit positions and reset values for the event router
`ifndef EVT_PARAMS_SVH
`define EVT_PARAMS_SVH

`define EVT_ADR_CFG       4'h0
`define EVT_ADR_STATUS    4'h4
`define EVT_ADR_SAG_LIM   4'h8
`define EVT_ADR_SURGE_LIM 4'hC

`define EVT_ADR_W         4
`define EVT_CFG_RESET     32'h0000_0000
`define EVT_CFG_WMASK     32'h1FFF_CFFF
`define EVT_LIM_RESET     32'h0000_0000

`define EVT_BIT_HOT_P2    28
`define EVT_BIT_HOT_P1    27
`define EVT_BIT_HOT_CLR   26
`define EVT_BIT_HOT_LAT   25
`define EVT_BIT_HOT_SIM   24
`define EVT_LSB_P2        20
`define EVT_LSB_P1        16
`define EVT_BIT_MAN_B     15
`define EVT_BIT_MAN_A     14
`define EVT_LSB_CLR       8
`define EVT_LSB_LAT       4
`define EVT_LSB_SIM       0

`define EVT_NUM           5
`define EVT_TEMP_W        10

`endif

// ### core/evt_pkg.sv
// Types shared by the event router files
package evt_pkg;
   // Event index order: amps, watts, swell, dip, hot
   typedef enum logic [2:0] {
      EV_AMPS  = 3'h0,
      EV_WATTS = 3'h1,
      EV_SWELL = 3'h2,
      EV_DIP   = 3'h3,
      EV_HOT   = 3'h4
   } event_e;

   typedef enum logic [1:0] {
      NV_IDLE    = 2'h0,
      NV_ARMED   = 2'h1,
      NV_SAVED   = 2'h3
   } nv_state_e;
endpackage : evt_pkg

// ### core/event_flag.sv
// One event flag: condition, simulation, latch and self-clearing clear
module event_flag (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic eval_i,
   input  wire logic cond_i,
   input  wire logic sim_i,
   input  wire logic latch_i,
   input  wire logic clear_i,
   output logic      active_o
);
   logic seen_ff;
   logic hold_ff;

   // Raw state refreshes only when the source is evaluated
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         seen_ff <= 1'b0;
      end else if (eval_i) begin
         seen_ff <= cond_i;
      end
   end

   // A new hit wins over a clear in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hold_ff <= 1'b0;
      end else if (latch_i && (seen_ff || sim_i)) begin
         hold_ff <= 1'b1;
      end else if (clear_i || !latch_i) begin
         hold_ff <= 1'b0;
      end
   end

   assign active_o = ((seen_ff || sim_i) && !clear_i) || hold_ff;
endmodule : event_flag

// ### core/nv_trigger.sv
// Save/restore trigger with hysteresis between two voltage levels
module nv_trigger #(
   parameter int W = 32
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         eval_i,
   input  wire logic [W-1:0] volts_i,
   input  wire logic [W-1:0] save_trigger_level_i,
   input  wire logic [W-1:0] restore_trigger_level_i,
   output logic              save_o,
   output logic              restore_o
);
   evt_pkg::nv_state_e state_ff;

   // Restore only on the first sample above the high level after reset, save only on the way down
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff  <= evt_pkg::NV_IDLE;
         save_o    <= 1'b0;
         restore_o <= 1'b0;
      end else begin
         save_o    <= 1'b0;
         restore_o <= 1'b0;
         if (eval_i) begin
            case (state_ff)
               evt_pkg::NV_IDLE: begin
                  if (volts_i > restore_trigger_level_i) begin
                     restore_o <= 1'b1;
                     state_ff  <= evt_pkg::NV_ARMED;
                  end
               end
               evt_pkg::NV_ARMED: begin
                  if (volts_i < save_trigger_level_i) begin
                     save_o   <= 1'b1;
                     state_ff <= evt_pkg::NV_SAVED;
                  end
               end
               evt_pkg::NV_SAVED: begin
                  if (volts_i > restore_trigger_level_i) begin
                     state_ff <= evt_pkg::NV_ARMED;
                  end
               end
               default: begin
                  state_ff <= evt_pkg::NV_IDLE;
               end
            endcase
         end
      end
   end
endmodule : nv_trigger

// ### test/power_event_detect_and_pin_map_sva.sv
// Port-level checks for the event router
`include "evt_params.svh"
module power_event_detect_and_pin_map_sva (
   input wire logic                  clk_i,
   input wire logic                  rst_i,
   input wire logic                  cyc_i,
   input wire logic                  stb_i,
   input wire logic                  we_i,
   input wire logic [`EVT_ADR_W-1:0] adr_i,
   input wire logic [31:0]           dat_o,
   input wire logic                  ack_o,
   input wire logic                  data_ready_i,
   input wire logic                  compute_done_i,
   input wire logic                  alert_pin_a_o,
   input wire logic                  alert_pin_b_o,
   input wire logic                  nv_save_o,
   input wire logic                  nv_restore_o
);
   logic cause;
   // Pins may only move after an evaluation pulse or a register write
   assign cause = data_ready_i | compute_done_i | (cyc_i & stb_i & we_i);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_req; cyc_i && stb_i && !ack_o; endsequence
   sequence s_ans; ack_o ##1 !ack_o; endsequence
   chk_ack_one_cycle: assert property (s_req |=> s_ans)
      else $error("ack not a single cycle after request");
   chk_cfg_read_zeros: assert property (ack_o && !$past(we_i) && $past(adr_i) == `EVT_ADR_CFG
      |-> dat_o[31:29] == 3'h0 && dat_o[13:12] == 2'h0 && !dat_o[26] && dat_o[11:8] == 4'h0)
      else $error("config read shows reserved or clear bits");
   chk_pin_a_cause: assert property ($changed(alert_pin_a_o)
      |-> $past(cause) || $past(cause, 2) || $past(cause, 3))
      else $error("pin a moved without cause");
   chk_pin_b_cause: assert property ($changed(alert_pin_b_o)
      |-> $past(cause) || $past(cause, 2) || $past(cause, 3))
      else $error("pin b moved without cause");
   chk_save_pulse: assert property (nv_save_o |=> !nv_save_o)
      else $error("save pulse too long");
   chk_restore_pulse: assert property (nv_restore_o |=> !nv_restore_o)
      else $error("restore pulse too long");
   chk_nv_sample_cause: assert property ((nv_save_o || nv_restore_o)
      |-> $past(data_ready_i) || $past(data_ready_i, 2) || $past(data_ready_i, 3))
      else $error("nv trigger without sample");
   chk_nv_exclusive: assert property (!(nv_save_o && nv_restore_o))
      else $error("save and restore together");
   chk_reset_quiet: assert property (disable iff (1'b0) rst_i
      |=> !ack_o && !alert_pin_a_o && !alert_pin_b_o && !nv_save_o && !nv_restore_o)
      else $error("outputs active after reset");
endmodule : power_event_detect_and_pin_map_sva

bind power_event_detect_and_pin_map power_event_detect_and_pin_map_sva u_sva (
   .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
   .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .data_ready_i(data_ready_i),
   .compute_done_i(compute_done_i), .alert_pin_a_o(alert_pin_a_o),
   .alert_pin_b_o(alert_pin_b_o), .nv_save_o(nv_save_o), .nv_restore_o(nv_restore_o));

// ### test/alert_host.sv
// Host side model: counts interrupt requests on both alert pins
module alert_host (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic pin_a_i,
   input  wire logic pin_b_i,
   output int        rises_a_o,
   output int        rises_b_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic a_ff;
   logic b_ff;
   // Active-high request: a rising level is one interrupt
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         a_ff      <= 1'b0;
         b_ff      <= 1'b0;
         rises_a_o <= 0;
         rises_b_o <= 0;
      end else begin
         a_ff <= pin_a_i;
         b_ff <= pin_b_i;
         if (pin_a_i && !a_ff) rises_a_o <= rises_a_o + 1;
         if (pin_b_i && !b_ff) rises_b_o <= rises_b_o + 1;
      end
   end
endmodule : alert_host

// ### test/power_event_detect_and_pin_map_tb.sv
// Register-level tests of the event router
`define CHK(nm, e, g) comparisons++; if ((g) !== (e)) begin n_mismatch++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end
module power_event_detect_and_pin_map_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, data_ready_i = 0, compute_done_i = 0;
   logic [3:0]  adr_i = 0;
   logic [31:0] dat_i = 0, dat_o, tv = 0, rv = 0, ra = 0, wa = 0, sl = 0, rl = 0;
   logic [9:0]  th = 0, hl = 0;
   logic        ack_o, alert_pin_a_o, alert_pin_b_o, nv_save_o, nv_restore_o;
   int n_mismatch = 0, comparisons = 0, cycles = 0, n_save = 0, n_rest = 0, rises_a, rises_b, b0;
   int sim_b[5] = '{0, 1, 3, 2, 24};
   int p1_b[5] = '{18, 19, 17, 16, 27};
   int p2_b[5] = '{22, 23, 21, 20, 28};
   always #2.5 clk_i = ~clk_i;
   power_event_detect_and_pin_map u_power_event_detect_and_pin_map (.clk_i(clk_i), .rst_i(rst_i),
      .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i),
      .dat_o(dat_o), .ack_o(ack_o), .data_ready_i(data_ready_i), .compute_done_i(compute_done_i),
      .trailing_mean_square_volts_i(tv), .rms_volts_i(rv), .rms_amps_i(ra), .active_watts_i(wa),
      .thermistor_i(th), .amps_limit_i(32'hA), .watts_limit_i(32'hA), .hot_limit_i(hl),
      .save_trigger_level_i(sl), .restore_trigger_level_i(rl), .alert_pin_a_o(alert_pin_a_o),
      .alert_pin_b_o(alert_pin_b_o), .nv_save_o(nv_save_o), .nv_restore_o(nv_restore_o));
   alert_host u_alert_host (.clk_i(clk_i), .rst_i(rst_i), .pin_a_i(alert_pin_a_o),
      .pin_b_i(alert_pin_b_o), .rises_a_o(rises_a), .rises_b_o(rises_b));
   always @(posedge clk_i) begin
      cycles++;
      if (nv_save_o === 1'b1) n_save++;
      if (nv_restore_o === 1'b1) n_rest++;
      // Ceiling is more than ten times the expected run length
      if (cycles == 5000) begin
         n_mismatch++;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : stop_test
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= a; dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      if (n >= 50) n_mismatch++;
      q = dat_o;
      cyc_i <= 0; stb_i <= 0; we_i <= 0;
   endtask : wb
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1, a, d, q);
      repeat (3) @(posedge clk_i);
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      logic [31:0] q;
      wb(0, a, 32'h0, q);
      `CHK("rdata", e, q)
   endtask : rd
   // Pins are registered after the flag, so allow three edges to settle
   task automatic pulse(input logic dr, input logic cd);
      @(posedge clk_i);
      data_ready_i <= dr; compute_done_i <= cd;
      @(posedge clk_i);
      data_ready_i <= 0; compute_done_i <= 0;
      repeat (3) @(posedge clk_i);
   endtask : pulse
   task automatic pins(input logic a, input logic b);
      `CHK("pin_a", a, alert_pin_a_o)
      `CHK("pin_b", b, alert_pin_b_o)
   endtask : pins
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 0;
      rd(4'h0, 32'h0);
      pins(0, 0);
      wr(4'h0, 32'hFFFF_FFFF);
      rd(4'h0, 32'h1BFF_C0FF);
      wr(4'h2, 32'h1234_5678);
      rd(4'h2, 32'h0);
      wr(4'h0, 32'h0000_4000);
      pins(1, 0);
      wr(4'h0, 32'h0001_8000);
      pins(0, 1);
      b0 = rises_b;
      for (int i = 0; i < 5; i++) begin
         wr(4'h0, (32'h1 << sim_b[i]) | (32'h1 << p2_b[i]));
         pulse(1, 1);
         pins(0, 1);
         rd(4'h4, 32'h1 << i);
         wr(4'h0, (32'h1 << sim_b[i]) | (32'h1 << p1_b[i]));
         pulse(1, 1);
         pins(1, 0);
      end
      `CHK("rises_b", 4, rises_b - b0)
      wr(4'h8, 32'd100);
      wr(4'hC, 32'd200);
      wr(4'h0, 32'h0012_0000);
      tv <= 32'd50;
      pulse(0, 1);
      pins(0, 0);
      pulse(1, 0);
      pins(0, 1);
      tv <= 32'd150;
      pulse(1, 0);
      pins(0, 0);
      tv <= 32'd250;
      pulse(1, 0);
      pins(1, 0);
      tv <= 32'd150;
      wr(4'h0, 32'h0004_0010);
      ra <= 32'd20;
      pulse(1, 0);
      pins(0, 0);
      pulse(0, 1);
      pins(1, 0);
      ra <= 32'd5;
      pulse(0, 1);
      pins(1, 0);
      wr(4'h0, 32'h0004_0810);
      pins(0, 0);
      rd(4'h0, 32'h0004_0010);
      wr(4'h0, 32'h1008_0000);
      wa <= 32'd20;
      hl <= 10'h3FE;
      th <= 10'h3FF;
      pulse(0, 1);
      pins(1, 1);
      wa <= 32'd0;
      th <= 10'h0;
      pulse(0, 1);
      pins(0, 0);
      sl <= 32'd100;
      rl <= 32'd300;
      rv <= 32'd400;
      pulse(1, 0);
      `CHK("restores", 1, n_rest)
      rv <= 32'd200;
      pulse(1, 0);
      `CHK("saves", 0, n_save)
      rv <= 32'd50;
      pulse(1, 0);
      `CHK("saves", 1, n_save)
      rd(4'h4, 32'h0);
      pins(0, 0);
      stop_test();
   end
endmodule : power_event_detect_and_pin_map_tb
